// ---- verilog/rx_sup_pkg.sv ----
package rx_sup_pkg;
    // System clock
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Charge-done qualification time, must be exceeded
    localparam int unsigned CD_HOLD_NS = 50_000;
    localparam int unsigned CD_CYCLES = CD_HOLD_NS / CLK_PERIOD_NS + 1;
    // Blanking of low-current detection after power starts
    localparam int unsigned BLANK_S = 5;
    localparam int unsigned BLANK_CYCLES_DEF = BLANK_S * CLK_HZ;
    // APB byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0c;
    localparam logic [7:0] ADDR_POWER = 8'h10;
    localparam logic [7:0] ADDR_ADJUST = 8'h14;
    // Control fields
    localparam int unsigned CTRL_LOWCUR_EN = 0;
    localparam logic [0:0] CTRL_RESET = 1'h1;
    // Adjust register fields
    localparam int unsigned ADJ_GAIN_LSB = 0;
    localparam int unsigned ADJ_OFS_LSB = 8;
    localparam int unsigned ADJ_LOWOFS_LSB = 16;
    localparam logic [23:0] ADJUST_RESET = 24'h000080;
    // Interrupt event bits
    localparam int unsigned NIRQ = 6;
    localparam int unsigned IRQ_CHARGE = 0;
    localparam int unsigned IRQ_FULL = 1;
    localparam int unsigned IRQ_OVERCUR = 2;
    localparam int unsigned IRQ_OVERTEMP = 3;
    localparam int unsigned IRQ_XSUPPLY = 4;
    localparam int unsigned IRQ_EPT_SENT = 5;
    // Received-power packet header and gain unity point
    localparam logic [7:0] POWER_HEADER = 8'h04;
    localparam int unsigned GAIN_FRAC = 7;
    // End-transfer reason codes
    localparam logic [7:0] EPT_FULL = 8'h01;
    localparam logic [7:0] EPT_OVERTEMP = 8'h03;
    localparam logic [7:0] EPT_OVERCUR = 8'h05;
    localparam logic [7:0] EPT_XSUPPLY = 8'h00;
    // Supervisor states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CHARGE = 5'h02,
        ST_DRAIN = 5'h04,
        ST_EPT = 5'h08,
        ST_HALT = 5'h10
    } sup_state_e;
endpackage : rx_sup_pkg

// ---- verilog/rx_charge_supervisor.sv ----
// Decided for this implementation: the APB slave port and the register offsets.
module rx_charge_supervisor #(
    parameter int unsigned BLANK_CYCLES = rx_sup_pkg::BLANK_CYCLES_DEF
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CHARGE_DONE_INPUT,
    input wire logic DONE_CURRENT_LOW,
    input wire logic DONE_CURRENT_SET_HIGH,
    input wire logic OVER_CURRENT,
    input wire logic THERMISTOR_HOT,
    input wire logic SUPPLY_ABOVE_ON,
    input wire logic SUPPLY_BELOW_OFF,
    input wire logic POWER_OFFSET_SET_HIGH,
    input wire logic LOW_CURRENT_OFFSET_SELECT,
    input wire logic CURRENT_BELOW_OFFSET,
    input wire logic CURRENT_ABOVE_RISE,
    input wire logic CURRENT_BELOW_FALL,
    input wire logic POWER_PRESENT,
    input wire logic OUTPUT_AT_ZERO,
    input wire logic [7:0] MEASURED_POWER,
    input wire logic EPT_ACK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic OUTPUT_ENABLE,
    output logic EPT_VALID,
    output logic [7:0] EPT_CODE,
    output logic [7:0] POWER_HEADER_OUT,
    output logic [7:0] RECEIVED_POWER_FIELD,
    output logic STATUS_LED,
    output logic EXTERNAL_SWITCH_DRIVE,
    output logic RECT_TARGET_HIGH,
    output logic IRQ
);
    import rx_sup_pkg::*;

    localparam int unsigned NIN = 13;
    // Synchroniser stages for all comparator and pin flags except output-zero and EPT_ACK
    logic [NIN-1:0] in_meta_r;
    logic [NIN-1:0] in_sync_r;
    logic cd_s, dcl_s, dset_s, oc_s, ot_s, xon_s, xoff_s;
    logic ofs_hi_s, lsel_s, below_ofs_s, rise_s, fall_s, pwr_s;
    logic zero_s;
    logic [7:0] meas_r; // Measured power, taken as synchronous
    // Debounce and blanking counters
    logic [10:0] cd_cnt_r;
    logic cd_full_r; // Qualified charge-done
    logic [31:0] blank_cnt_r;
    logic armed_r; // Low-current check allowed
    // Supervisor state
    sup_state_e state_r;
    sup_state_e state_nxt;
    logic out_en_r, ept_valid_r, led_r, xsw_r, rect_hi_r;
    logic [7:0] ept_code_r;
    logic [7:0] power_r;
    // Software registers
    logic [0:0] ctrl_r;
    logic [23:0] adjust_r;
    logic [NIRQ-1:0] irq_stat_r;
    logic [NIRQ-1:0] irq_mask_r;
    logic irq_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    // Events
    logic cur_full, full_evt, fault_evt;
    logic [7:0] fault_code;
    logic [NIRQ-1:0] evt;
    logic wr_en;

    // Saturating 8-bit add
    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[8] ? 8'hff : s[7:0];
    endfunction : sat_add

    // True when an address maps to a register
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == ADDR_CTRL) || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK)
            || (a == ADDR_STATE) || (a == ADDR_POWER) || (a == ADDR_ADJUST);
    endfunction : addr_hit

    // Two-stage synchroniser, first stage read only by second
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            in_meta_r <= '0;
            in_sync_r <= '0;
        end else begin
            in_meta_r <= {CHARGE_DONE_INPUT, DONE_CURRENT_LOW, DONE_CURRENT_SET_HIGH,
                OVER_CURRENT, THERMISTOR_HOT, SUPPLY_ABOVE_ON, SUPPLY_BELOW_OFF,
                POWER_OFFSET_SET_HIGH, LOW_CURRENT_OFFSET_SELECT, CURRENT_BELOW_OFFSET,
                CURRENT_ABOVE_RISE, CURRENT_BELOW_FALL, POWER_PRESENT};
            in_sync_r <= in_meta_r;
        end
    end
    assign {cd_s, dcl_s, dset_s, oc_s, ot_s, xon_s, xoff_s, ofs_hi_s, lsel_s, below_ofs_s,
        rise_s, fall_s, pwr_s} = in_sync_r;

    // Output-zero flag and measured power
    logic zero_meta_r, zero_r;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            zero_meta_r <= 1'b0;
            zero_r <= 1'b0;
            meas_r <= 8'h00;
        end else begin
            zero_meta_r <= OUTPUT_AT_ZERO;
            zero_r <= zero_meta_r;
            meas_r <= MEASURED_POWER;
        end
    end
    assign zero_s = zero_r;

    // Charge-done qualification: high for CD_CYCLES + 1 cycles in a row
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cd_cnt_r <= '0;
            cd_full_r <= 1'b0;
        end else if (!cd_s) begin
            cd_cnt_r <= '0; // Low releases the request
            cd_full_r <= 1'b0;
        end else if (cd_cnt_r != 11'(CD_CYCLES)) begin
            cd_cnt_r <= cd_cnt_r + 11'h001;
        end else begin
            cd_full_r <= 1'b1;
        end
    end

    // Blanking timer runs from the start of charging
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || state_r != ST_CHARGE) begin
            blank_cnt_r <= '0;
            armed_r <= 1'b0;
        end else if (blank_cnt_r != BLANK_CYCLES) begin
            blank_cnt_r <= blank_cnt_r + 32'h1;
        end else begin
            armed_r <= 1'b1;
        end
    end

    // Low-current full charge, gated by pin, input and software
    assign cur_full = dcl_s && armed_r && !cd_s && !dset_s
        && ctrl_r[CTRL_LOWCUR_EN];
    assign full_evt = cd_full_r || cur_full;
    // Faults ranked ahead of full charge
    always_comb begin
        fault_evt = 1'b1;
        if (oc_s) begin
            fault_code = EPT_OVERCUR;
        end else if (ot_s) begin
            fault_code = EPT_OVERTEMP;
        end else if (xon_s) begin
            fault_code = EPT_XSUPPLY;
        end else begin
            fault_code = EPT_FULL;
            fault_evt = 1'b0;
        end
    end

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                // Start only when nothing holds the output off
                if (pwr_s && !cd_s && !xsw_r && !fault_evt) begin
                    state_nxt = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                if (fault_evt) begin
                    state_nxt = ST_EPT;
                end else if (full_evt) begin
                    state_nxt = ST_DRAIN;
                end else if (!pwr_s) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DRAIN: begin
                // Wait for the output to collapse
                if (zero_s || fault_evt) begin
                    state_nxt = ST_EPT;
                end
            end
            ST_EPT: begin
                if (EPT_ACK) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                // Transmitter drops power before a restart
                if (!pwr_s) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Regulator output enable follows charging only
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            out_en_r <= 1'b0;
        end else begin
            out_en_r <= (state_nxt == ST_CHARGE);
        end
    end

    // End-transfer request held until the link takes it
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ept_valid_r <= 1'b0;
            ept_code_r <= EPT_FULL;
        end else if (state_r == ST_CHARGE && fault_evt) begin
            ept_valid_r <= 1'b1;
            ept_code_r <= fault_code;
        end else if (state_r == ST_DRAIN && fault_evt) begin
            ept_valid_r <= 1'b1;
            ept_code_r <= fault_code;
        end else if (state_r == ST_DRAIN && zero_s) begin
            ept_valid_r <= 1'b1;
            ept_code_r <= EPT_FULL;
        end else if (state_r == ST_EPT && EPT_ACK) begin
            ept_valid_r <= 1'b0;
        end
    end

    // LED lit only in the charging state
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            led_r <= 1'b0;
        end else begin
            led_r <= (state_nxt == ST_CHARGE);
        end
    end

    // External supply switch with comparator hysteresis
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            xsw_r <= 1'b0;
        end else if (xon_s) begin
            xsw_r <= 1'b1;
        end else if (xoff_s) begin
            xsw_r <= 1'b0;
        end
    end

    // Rectifier target chosen from separate rise and fall points
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rect_hi_r <= 1'b0;
        end else if (rise_s) begin
            rect_hi_r <= 1'b1;
        end else if (fall_s) begin
            rect_hi_r <= 1'b0;
        end
    end

    // Received power: gain in 1/128 steps, then offsets, saturated
    logic [15:0] prod;
    logic [7:0] scaled, ofs, lofs;
    always_comb begin
        prod = meas_r * adjust_r[ADJ_GAIN_LSB +: 8];
        scaled = (prod[15:GAIN_FRAC] > 9'h0ff) ? 8'hff : prod[GAIN_FRAC +: 8];
        ofs = ofs_hi_s ? 8'h00 : adjust_r[ADJ_OFS_LSB +: 8];
        lofs = (lsel_s && below_ofs_s) ? adjust_r[ADJ_LOWOFS_LSB +: 8] : 8'h00;
    end
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            power_r <= 8'h00;
        end else begin
            power_r <= sat_add(sat_add(scaled, ofs), lofs);
        end
    end

    // Interrupt events
    assign evt[IRQ_CHARGE] = (state_r == ST_IDLE) && (state_nxt == ST_CHARGE);
    assign evt[IRQ_FULL] = (state_r == ST_CHARGE) && (state_nxt == ST_DRAIN);
    assign evt[IRQ_OVERCUR] = oc_s && (state_r == ST_CHARGE);
    assign evt[IRQ_OVERTEMP] = ot_s && (state_r == ST_CHARGE);
    assign evt[IRQ_XSUPPLY] = xon_s && !xsw_r;
    assign evt[IRQ_EPT_SENT] = (state_r == ST_EPT) && EPT_ACK;

    // APB: one wait state, write lands on the ready edge
    assign wr_en = PSEL && PENABLE && pready_r && PWRITE;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= PSEL && PENABLE && !pready_r;
            pslverr_r <= PSEL && PENABLE && !pready_r && !addr_hit(PADDR);
            if (PSEL && !PENABLE && !PWRITE) begin
                // Read data captured in the setup cycle
                case (PADDR)
                    ADDR_CTRL: prdata_r <= {31'h0, ctrl_r};
                    ADDR_IRQ_STAT: prdata_r <= {26'h0, irq_stat_r};
                    ADDR_IRQ_MASK: prdata_r <= {26'h0, irq_mask_r};
                    ADDR_STATE: prdata_r <= {20'h0, xsw_r, rect_hi_r, armed_r, cd_full_r,
                        out_en_r, ept_valid_r, 1'b0, state_r};
                    ADDR_POWER: prdata_r <= {24'h0, power_r};
                    ADDR_ADJUST: prdata_r <= {8'h0, adjust_r};
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    // Writable registers
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ctrl_r <= CTRL_RESET;
            adjust_r <= ADJUST_RESET;
            irq_mask_r <= '0;
        end else if (wr_en) begin
            case (PADDR)
                ADDR_CTRL: ctrl_r <= PWDATA[0:0];
                ADDR_IRQ_MASK: irq_mask_r <= PWDATA[NIRQ-1:0];
                ADDR_ADJUST: adjust_r <= PWDATA[23:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Sticky status, write one to clear, new event wins
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            irq_stat_r <= '0;
        end else if (wr_en && PADDR == ADDR_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~PWDATA[NIRQ-1:0]) | evt;
        end else begin
            irq_stat_r <= irq_stat_r | evt;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign OUTPUT_ENABLE = out_en_r;
    assign EPT_VALID = ept_valid_r;
    assign EPT_CODE = ept_code_r;
    assign POWER_HEADER_OUT = POWER_HEADER;
    assign RECEIVED_POWER_FIELD = power_r;
    assign STATUS_LED = led_r;
    assign EXTERNAL_SWITCH_DRIVE = xsw_r;
    assign RECT_TARGET_HIGH = rect_hi_r;
    assign IRQ = irq_r;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_drain_entry;
        state_r == ST_CHARGE && full_evt && !fault_evt;
    endsequence
    sequence s_ept_full;
        state_r == ST_DRAIN ##1 (ept_valid_r && ept_code_r == EPT_FULL);
    endsequence

    chk_cd_qualify: assert property ($rose(cd_full_r) |-> cd_cnt_r == 11'(CD_CYCLES))
        else $error("charge-done qualified early");
    chk_full_drain: assert property (s_drain_entry |=> state_r == ST_DRAIN && !out_en_r)
        else $error("full charge did not shut output");
    chk_ept_zero: assert property ($rose(ept_valid_r) && ept_code_r == EPT_FULL
        |-> $past(zero_s))
        else $error("end-transfer sent before output zero");
    chk_full_ept: assert property (s_ept_full |-> $past(zero_s))
        else $error("full end-transfer without drain");
    chk_lowcur_gate: assert property (cur_full |-> armed_r && !cd_s && !dset_s)
        else $error("low-current check not gated");
    chk_blank_time: assert property ($rose(armed_r) |-> blank_cnt_r == BLANK_CYCLES)
        else $error("blanking time wrong");
    chk_fault_stop: assert property (state_r == ST_CHARGE && oc_s
        |=> !out_en_r && ept_valid_r && ept_code_r == EPT_OVERCUR)
        else $error("over-current not handled");
    chk_temp_stop: assert property (state_r == ST_CHARGE && ot_s && !oc_s
        |=> ept_valid_r && ept_code_r == EPT_OVERTEMP)
        else $error("over-temperature not handled");
    chk_led_charge: assert property (led_r |-> state_r == ST_CHARGE)
        else $error("LED lit outside charging");
    chk_xsw_on: assert property (xon_s |=> xsw_r)
        else $error("external switch not on");
    chk_xsw_off: assert property (xoff_s && !xon_s |=> !xsw_r)
        else $error("external switch not off");
    chk_rect_hyst: assert property (!rise_s && !fall_s |=> $stable(rect_hi_r))
        else $error("rectifier target moved inside band");
endmodule : rx_charge_supervisor

// ---- tb/tx_model.sv ----
// Transmitter side of the end-transfer link
module tx_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [3:0] dly,
    input wire logic ept_valid,
    output logic ept_ack,
    output logic power_present
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r; // Wait before acknowledging
    logic stop_r; // Power halted after end-transfer
    // Ack after the chosen delay, then stop power until re-enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 4'h0;
            stop_r <= 1'b0;
            ept_ack <= 1'b0;
        end else begin
            ept_ack <= 1'b0;
            if (!en) begin
                stop_r <= 1'b0;
            end
            if (ept_valid && !ept_ack && !stop_r) begin
                if (cnt_r == dly) begin
                    ept_ack <= 1'b1;
                    cnt_r <= 4'h0;
                    stop_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
    // Power only while enabled and not halted
    assign power_present = en && !stop_r;
endmodule : tx_model

// ---- tb/testbench.sv ----
// Self-checking bench for the charge supervisor
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import rx_sup_pkg::*;
    logic clk = 0, rst = 1, cd = 0, dcl = 0, dcs = 0, oc = 0, hot = 0, son = 0, soff = 1;
    logic posh = 0, lsel = 0, cbo = 0, crise = 0, cfall = 1, at0 = 0, pwr = 0;
    logic psel = 0, pen = 0, pw = 0, ack, pp, pready, pslverr, oe, ev, led, xsw, rth, irq, rerr;
    logic [7:0] mp = 8'h00, paddr = 8'h00, code, hdr, rpf;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0] dly = 4'h0;
    int failures = 0, tests_run = 0;
    logic [2:0] fl [4] = '{3'h4, 3'h2, 3'h1, 3'h7}; // Over-current, hot, supply, then all three together
    logic [7:0] fc [4] = '{EPT_OVERCUR, EPT_OVERTEMP, EPT_XSUPPLY, EPT_OVERCUR};
    rx_charge_supervisor #(.BLANK_CYCLES(50)) dut (.SYS_CLK(clk), .SYS_RST(rst),
        .CHARGE_DONE_INPUT(cd), .DONE_CURRENT_LOW(dcl), .DONE_CURRENT_SET_HIGH(dcs),
        .OVER_CURRENT(oc), .THERMISTOR_HOT(hot), .SUPPLY_ABOVE_ON(son), .SUPPLY_BELOW_OFF(soff),
        .POWER_OFFSET_SET_HIGH(posh), .LOW_CURRENT_OFFSET_SELECT(lsel),
        .CURRENT_BELOW_OFFSET(cbo), .CURRENT_ABOVE_RISE(crise), .CURRENT_BELOW_FALL(cfall),
        .POWER_PRESENT(pp), .OUTPUT_AT_ZERO(at0), .MEASURED_POWER(mp), .EPT_ACK(ack),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pw), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .OUTPUT_ENABLE(oe),
        .EPT_VALID(ev), .EPT_CODE(code), .POWER_HEADER_OUT(hdr), .RECEIVED_POWER_FIELD(rpf),
        .STATUS_LED(led), .EXTERNAL_SWITCH_DRIVE(xsw), .RECT_TARGET_HIGH(rth), .IRQ(irq));
    tx_model tx (.clk(clk), .rst(rst), .en(pwr), .dly(dly), .ept_valid(ev), .ept_ack(ack),
        .power_present(pp));
    // Free-running system clock
    always #25 clk = ~clk;
    // Compare and count
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Verdict and end of run
    task results();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // One APB transfer; ready, data and error taken at the rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pw <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        chk("pready", pready, 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // Read and compare one register
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", rdata, e);
    endtask : rd
    // Let settled values show
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Bounded wait for an end-transfer request
    task wait_ept();
        int n;
        n = 0;
        while (ev !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("ept_valid", ev, 1'b1);
    endtask : wait_ept
    // Drop and restore transmitter power
    task restart();
        @(posedge clk);
        pwr <= 1'b0;
        at0 <= 1'b0;
        cyc(5);
        @(posedge clk);
        pwr <= 1'b1;
        cyc(6);
    endtask : restart
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("header", hdr, POWER_HEADER);
        rd(ADDR_CTRL, 32'h1);
        rd(ADDR_ADJUST, 32'h80);
        rd(ADDR_STATE, 32'h1);
        chk("slverr", rerr, 1'b0);
        rd(8'h1c, 32'h0);
        chk("slverr", rerr, 1'b1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h3f);
        // Low-current end of charge, disabled then enabled
        dcl <= 1'b1;
        dcs <= 1'b1;
        restart();
        chk("led", led, 1'b1);
        cyc(80);
        chk("oe", oe, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        @(posedge clk) dcs <= 1'b0;
        cyc(6);
        chk("oe", oe, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        cyc(6);
        chk("oe", oe, 1'b0);
        chk("ev", ev, 1'b0);
        @(posedge clk) at0 <= 1'b1;
        wait_ept();
        chk("code", code, EPT_FULL);
        cyc(10);
        restart();
        cyc(14);
        chk("oe", oe, 1'b1);
        cyc(50);
        chk("oe", oe, 1'b0);
        @(posedge clk) at0 <= 1'b1;
        cyc(14);
        // Host full-charge request with current check held off
        restart();
        @(posedge clk) cd <= 1'b1;
        cyc(990);
        chk("oe", oe, 1'b1);
        cyc(20);
        chk("oe", oe, 1'b0);
        chk("ev", ev, 1'b0);
        @(posedge clk) at0 <= 1'b1;
        wait_ept();
        chk("code", code, EPT_FULL);
        cyc(10);
        restart();
        chk("led", led, 1'b0);
        @(posedge clk) cd <= 1'b0;
        dcl <= 1'b0;
        // Faults, alone and together, with prompt and slow acks
        for (int i = 0; i < 4; i++) begin
            restart();
            chk("led", led, 1'b1);
            @(posedge clk);
            oc <= fl[i][2];
            hot <= fl[i][1];
            son <= fl[i][0];
            soff <= !fl[i][0];
            dly <= 4'(i * 3);
            wait_ept();
            chk("code", code, fc[i]);
            chk("oe", oe, 1'b0);
            chk("led", led, 1'b0);
            chk("xsw", xsw, fl[i][0]);
            cyc(14);
            chk("ev", ev, 1'b0);
            @(posedge clk);
            {oc, hot, son, soff} <= 4'h1;
            cyc(5);
            chk("xsw", xsw, 1'b0);
        end
        // Interrupt status, mask and clear
        rd(ADDR_IRQ_STAT, 32'h3f);
        chk("irq", irq, 1'b1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        cyc(3);
        chk("irq", irq, 1'b0);
        apb(1'b1, ADDR_IRQ_STAT, 32'h3f);
        apb(1'b1, ADDR_IRQ_MASK, 32'h3f);
        rd(ADDR_IRQ_STAT, 32'h0);
        chk("irq", irq, 1'b0);
        // Received power: gain 80h unity, offset 10h, low-current offset 08h
        @(posedge clk) mp <= 8'h20;
        posh <= 1'b1;
        apb(1'b1, ADDR_ADJUST, 32'h081080);
        cyc(5);
        chk("rpf", rpf, 8'h20);
        @(posedge clk) posh <= 1'b0;
        cyc(5);
        chk("rpf", rpf, 8'h30);
        @(posedge clk) lsel <= 1'b1;
        cbo <= 1'b1;
        cyc(5);
        rd(ADDR_POWER, 32'h38);
        @(posedge clk) cbo <= 1'b0;
        cyc(5);
        chk("rpf", rpf, 8'h30);
        @(posedge clk) posh <= 1'b1;
        apb(1'b1, ADDR_ADJUST, 32'h40);
        cyc(5);
        chk("rpf", rpf, 8'h10);
        // Rectifier target hysteresis
        @(posedge clk) {crise, cfall} <= 2'h2;
        cyc(5);
        chk("rth", rth, 1'b1);
        @(posedge clk) crise <= 1'b0;
        cyc(5);
        chk("rth", rth, 1'b1);
        @(posedge clk) cfall <= 1'b1;
        cyc(5);
        chk("rth", rth, 1'b0);
        results();
    end
endmodule : testbench
